// ### jtag_decode_defs.svh
`ifndef JTAG_DECODE_DEFS_SVH
`define JTAG_DECODE_DEFS_SVH

// ==========================================================
// instruction register layout
`define IR_W            16
`define IR_RESET        16'h0000
`define IR_CAPTURE      16'h0001
// ==========================================================
// instruction codes
`define IR_EXTEST       16'h0000
`define IR_SAMPLE       16'h0002
`define IR_IDCODE       16'h0004
`define IR_FLASH_CTRL   16'h0082
`define IR_FLASH_DATA   16'h0083
`define IR_FLASH_ADDR   16'h0084
`define IR_FLASH_SCALE  16'h0085
`define IR_BYPASS       16'hFFFF
// ==========================================================
// data register lengths and bit positions
`define BYPASS_LEN      1
`define IDCODE_LEN      32
`define BSR_LEN_LARGE   126
`define BSR_LEN_SMALL   118
`define SHIFT_IN_BIT    0
`define BYPASS_CAPTURE  1'b0
`define FLASH_CTRL_W    8
`define FLASH_DATA_W    8
`define FLASH_ADDR_W    16
`define FLASH_SCALE_W   8
// ==========================================================
// synchroniser depth
`define SYNC_STAGES     3

`endif

// ### jtag_decode_pkg.sv
package jtag_decode_pkg;

  // ========================================================
  // test access port controller states
  typedef enum logic [3:0] {
    tap_reset,
    tap_idle,
    tap_sel_dr,
    tap_cap_dr,
    tap_shift_dr,
    tap_exit1_dr,
    tap_pause_dr,
    tap_exit2_dr,
    tap_upd_dr,
    tap_sel_ir,
    tap_cap_ir,
    tap_shift_ir,
    tap_exit1_ir,
    tap_pause_ir,
    tap_exit2_ir,
    tap_upd_ir
  } tap_state_e;

endpackage : jtag_decode_pkg

// ### jtag_instruction_decode.sv
`timescale 1ns/1ns
`include "jtag_decode_defs.svh"

// How it works
// - four dedicated pins: clock, mode, data in/out
// - sixteen-bit instruction register resets to external-test
// - decode sample, identification and bypass codes
// - code zero routes boundary chain to output
// - address register supplies every flash access address
// - scale register drives timer and read-always
// - three scan and four flash data registers
// - shifting follows the standard TAP state machine
// - external-test updates pins; sample only captures
// - boundary chain 126 or 118 bits long
module jtag_instruction_decode #(
  parameter int          BSR_LEN = `BSR_LEN_LARGE,  // 118 on small package
  parameter logic [31:0] IDCODE  = 32'h1234_5001    // arbitrary value
) (
  input  wire logic                      mclk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdo_oe,
  input  wire logic [BSR_LEN-1:0]        bsr_capture,
  output logic      [BSR_LEN-1:0]        bsr_update,
  output logic                           bsr_drive,
  output logic      [`IR_W-1:0]          instr,
  input  wire logic [`FLASH_DATA_W-1:0]  flash_rdata,
  output logic      [`FLASH_CTRL_W-1:0]  flash_ctrl_reg,
  output logic      [`FLASH_DATA_W-1:0]  flash_data_reg,
  output logic                           flash_data_wr,
  output logic      [`FLASH_ADDR_W-1:0]  flash_addr_reg,
  output logic      [`FLASH_SCALE_W-1:0] flash_timing_scale_reg
);

  // ========================================================
  // pin sampling
  logic       tck_s;     // accepted test clock level
  logic       tms_s;     // accepted mode level
  logic       tdi_s;     // accepted data level

  // test pins cross from the tester clock domain
  pin_sync #(.W(3)) u_sync (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .pin   ({tdi, tms, tck}),
    .level ({tdi_s, tms_s, tck_s})
  );

  // ========================================================
  // state
  jtag_decode_pkg::tap_state_e st_q, st_d;  // tap controller
  logic               tck_prev_q, tck_prev_d;  // last tck level
  logic [`IR_W-1:0]   ir_sh_q, ir_sh_d;        // instruction shifter
  logic [`IR_W-1:0]   ir_q, ir_d;              // active instruction
  logic [BSR_LEN-1:0] dr_sh_q, dr_sh_d;        // shared data shifter
  logic [BSR_LEN-1:0] bsr_q, bsr_d;            // boundary update latch
  logic               drive_q, drive_d;        // boundary drives pins
  logic [`FLASH_CTRL_W-1:0]  fctl_q, fctl_d;   // flash control
  logic [`FLASH_DATA_W-1:0]  fdat_q, fdat_d;   // flash data
  logic                      fwr_q, fwr_d;     // flash data written
  logic [`FLASH_ADDR_W-1:0]  fadr_q, fadr_d;   // flash address
  logic [`FLASH_SCALE_W-1:0] fscl_q, fscl_d;   // flash scale
  logic               tdo_q, tdo_d;            // output data
  logic               oe_q, oe_d;              // output enable
  logic               tck_rise;                // rising test clock
  logic               tck_fall;                // falling test clock
  int                 dr_len;                  // selected chain length

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // ========================================================
  // data register selection by instruction
  always_comb begin
    case (ir_q)
      `IR_EXTEST, `IR_SAMPLE: dr_len = BSR_LEN;
      `IR_IDCODE:             dr_len = `IDCODE_LEN;
      `IR_FLASH_CTRL:         dr_len = `FLASH_CTRL_W;
      `IR_FLASH_DATA:         dr_len = `FLASH_DATA_W;
      `IR_FLASH_ADDR:         dr_len = `FLASH_ADDR_W;
      `IR_FLASH_SCALE:        dr_len = `FLASH_SCALE_W;
      default:                dr_len = `BYPASS_LEN;
    endcase
  end

  // ========================================================
  // next values of controller, shifters and registers
  always_comb begin
    st_d       = st_q;
    tck_prev_d = tck_s;
    ir_sh_d    = ir_sh_q;
    ir_d       = ir_q;
    dr_sh_d    = dr_sh_q;
    bsr_d      = bsr_q;
    drive_d    = (ir_q == `IR_EXTEST);
    fctl_d     = fctl_q;
    fdat_d     = fdat_q;
    fwr_d      = 1'b0;
    fadr_d     = fadr_q;
    fscl_d     = fscl_q;
    tdo_d      = tdo_q;
    oe_d       = oe_q;
    if (tck_rise) begin
      // standard controller transitions on the mode pin
      case (st_q)
        jtag_decode_pkg::tap_reset:    st_d = tms_s ? jtag_decode_pkg::tap_reset
                                                    : jtag_decode_pkg::tap_idle;
        jtag_decode_pkg::tap_idle:     st_d = tms_s ? jtag_decode_pkg::tap_sel_dr
                                                    : jtag_decode_pkg::tap_idle;
        jtag_decode_pkg::tap_sel_dr:   st_d = tms_s ? jtag_decode_pkg::tap_sel_ir
                                                    : jtag_decode_pkg::tap_cap_dr;
        jtag_decode_pkg::tap_cap_dr:   st_d = tms_s ? jtag_decode_pkg::tap_exit1_dr
                                                    : jtag_decode_pkg::tap_shift_dr;
        jtag_decode_pkg::tap_shift_dr: st_d = tms_s ? jtag_decode_pkg::tap_exit1_dr
                                                    : jtag_decode_pkg::tap_shift_dr;
        jtag_decode_pkg::tap_exit1_dr: st_d = tms_s ? jtag_decode_pkg::tap_upd_dr
                                                    : jtag_decode_pkg::tap_pause_dr;
        jtag_decode_pkg::tap_pause_dr: st_d = tms_s ? jtag_decode_pkg::tap_exit2_dr
                                                    : jtag_decode_pkg::tap_pause_dr;
        jtag_decode_pkg::tap_exit2_dr: st_d = tms_s ? jtag_decode_pkg::tap_upd_dr
                                                    : jtag_decode_pkg::tap_shift_dr;
        jtag_decode_pkg::tap_upd_dr:   st_d = tms_s ? jtag_decode_pkg::tap_sel_dr
                                                    : jtag_decode_pkg::tap_idle;
        jtag_decode_pkg::tap_sel_ir:   st_d = tms_s ? jtag_decode_pkg::tap_reset
                                                    : jtag_decode_pkg::tap_cap_ir;
        jtag_decode_pkg::tap_cap_ir:   st_d = tms_s ? jtag_decode_pkg::tap_exit1_ir
                                                    : jtag_decode_pkg::tap_shift_ir;
        jtag_decode_pkg::tap_shift_ir: st_d = tms_s ? jtag_decode_pkg::tap_exit1_ir
                                                    : jtag_decode_pkg::tap_shift_ir;
        jtag_decode_pkg::tap_exit1_ir: st_d = tms_s ? jtag_decode_pkg::tap_upd_ir
                                                    : jtag_decode_pkg::tap_pause_ir;
        jtag_decode_pkg::tap_pause_ir: st_d = tms_s ? jtag_decode_pkg::tap_exit2_ir
                                                    : jtag_decode_pkg::tap_pause_ir;
        jtag_decode_pkg::tap_exit2_ir: st_d = tms_s ? jtag_decode_pkg::tap_upd_ir
                                                    : jtag_decode_pkg::tap_shift_ir;
        jtag_decode_pkg::tap_upd_ir:   st_d = tms_s ? jtag_decode_pkg::tap_sel_dr
                                                    : jtag_decode_pkg::tap_idle;
        default:                       st_d = jtag_decode_pkg::tap_reset;
      endcase
      // actions of the state being left
      case (st_q)
        jtag_decode_pkg::tap_reset: begin
          ir_d = `IR_RESET;
        end
        jtag_decode_pkg::tap_cap_ir: begin
          ir_sh_d = `IR_CAPTURE;
        end
        jtag_decode_pkg::tap_shift_ir: begin
          ir_sh_d = {tdi_s, ir_sh_q[`IR_W-1:1]};
        end
        jtag_decode_pkg::tap_upd_ir: begin
          ir_d = ir_sh_q;
        end
        jtag_decode_pkg::tap_cap_dr: begin
          dr_sh_d = '0;
          case (ir_q)
            `IR_EXTEST, `IR_SAMPLE: dr_sh_d = bsr_capture;
            `IR_IDCODE:     dr_sh_d[`IDCODE_LEN-1:0] = IDCODE;
            `IR_FLASH_CTRL: dr_sh_d[`FLASH_CTRL_W-1:0] = fctl_q;
            `IR_FLASH_DATA: dr_sh_d[`FLASH_DATA_W-1:0] = flash_rdata;
            `IR_FLASH_ADDR: dr_sh_d[`FLASH_ADDR_W-1:0] = fadr_q;
            `IR_FLASH_SCALE: dr_sh_d[`FLASH_SCALE_W-1:0] = fscl_q;
            default:        dr_sh_d[`SHIFT_IN_BIT] = `BYPASS_CAPTURE;
          endcase
        end
        jtag_decode_pkg::tap_shift_dr: begin
          // shift toward bit zero, enter at the chain's top bit
          dr_sh_d = dr_sh_q >> 1;
          dr_sh_d[dr_len-1] = tdi_s;
        end
        jtag_decode_pkg::tap_upd_dr: begin
          case (ir_q)
            `IR_EXTEST:     bsr_d = dr_sh_q;
            `IR_FLASH_CTRL: fctl_d = dr_sh_q[`FLASH_CTRL_W-1:0];
            `IR_FLASH_DATA: begin
              fdat_d = dr_sh_q[`FLASH_DATA_W-1:0];
              fwr_d  = 1'b1;
            end
            `IR_FLASH_ADDR: fadr_d = dr_sh_q[`FLASH_ADDR_W-1:0];
            `IR_FLASH_SCALE: fscl_d = dr_sh_q[`FLASH_SCALE_W-1:0];
            default:        bsr_d = bsr_q;  // sample and others: no update
          endcase
        end
        default: ;  // other states hold
      endcase
    end
    // output changes on the falling test clock
    if (tck_fall) begin
      oe_d  = (st_q == jtag_decode_pkg::tap_shift_ir) ||
              (st_q == jtag_decode_pkg::tap_shift_dr);
      tdo_d = (st_q == jtag_decode_pkg::tap_shift_ir) ? ir_sh_q[`SHIFT_IN_BIT]
                                                      : dr_sh_q[`SHIFT_IN_BIT];
    end
  end

  // ========================================================
  // register all state
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q       <= jtag_decode_pkg::tap_reset;
      tck_prev_q <= 1'b0;
      ir_sh_q    <= `IR_RESET;
      ir_q       <= `IR_RESET;
      dr_sh_q    <= '0;
      bsr_q      <= '0;
      drive_q    <= 1'b0;
      fctl_q     <= '0;
      fdat_q     <= '0;
      fwr_q      <= 1'b0;
      fadr_q     <= '0;
      fscl_q     <= '0;
      tdo_q      <= 1'b0;
      oe_q       <= 1'b0;
    end else if (ce) begin
      st_q       <= st_d;
      tck_prev_q <= tck_prev_d;
      ir_sh_q    <= ir_sh_d;
      ir_q       <= ir_d;
      dr_sh_q    <= dr_sh_d;
      bsr_q      <= bsr_d;
      drive_q    <= drive_d;
      fctl_q     <= fctl_d;
      fdat_q     <= fdat_d;
      fwr_q      <= fwr_d;
      fadr_q     <= fadr_d;
      fscl_q     <= fscl_d;
      tdo_q      <= tdo_d;
      oe_q       <= oe_d;
    end
  end

  // ========================================================
  // outputs
  assign tdo                    = tdo_q;
  assign tdo_oe                 = oe_q;
  assign bsr_update             = bsr_q;
  assign bsr_drive              = drive_q;
  assign instr                  = ir_q;
  assign flash_ctrl_reg         = fctl_q;
  assign flash_data_reg         = fdat_q;
  assign flash_data_wr          = fwr_q;
  assign flash_addr_reg         = fadr_q;
  assign flash_timing_scale_reg = fscl_q;

  // ========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_rise_in(jtag_decode_pkg::tap_state_e s);
    ce && tck_rise && st_q == s;
  endsequence
  sequence s_upd(logic [`IR_W-1:0] code);
    s_rise_in(jtag_decode_pkg::tap_upd_dr) ##0 ir_q == code;
  endsequence
  sequence s_cap(logic [`IR_W-1:0] code);
    s_rise_in(jtag_decode_pkg::tap_cap_dr) ##0 ir_q == code;
  endsequence

  chk_ir_reset_load: assert property (
    s_rise_in(jtag_decode_pkg::tap_reset) |=> ir_q == `IR_RESET)
    else $error("instruction not reset in test-logic-reset");
  chk_tap_to_reset: assert property (
    s_rise_in(jtag_decode_pkg::tap_sel_ir) ##0 tms_s
    |=> st_q == jtag_decode_pkg::tap_reset)
    else $error("controller missed reset transition");
  chk_bypass_capture: assert property (
    s_cap(`IR_BYPASS) |=> dr_sh_q[0] == `BYPASS_CAPTURE)
    else $error("bypass bit not captured as zero");
  chk_idcode_capture: assert property (
    s_cap(`IR_IDCODE) |=> dr_sh_q[`IDCODE_LEN-1:0] == IDCODE)
    else $error("identification value not captured");
  chk_extest_update: assert property (
    s_upd(`IR_EXTEST) |=> bsr_q == $past(dr_sh_q) ##1 drive_q)
    else $error("external-test update not applied");
  chk_sample_no_upd: assert property (
    (ce && ir_q == `IR_SAMPLE) |=> $stable(bsr_q) && !drive_q)
    else $error("sample instruction changed pin outputs");
  chk_addr_update: assert property (
    s_upd(`IR_FLASH_ADDR) |=> fadr_q == $past(dr_sh_q[`FLASH_ADDR_W-1:0]))
    else $error("flash address not updated");
  chk_scale_update: assert property (
    s_upd(`IR_FLASH_SCALE) |=> fscl_q == $past(dr_sh_q[`FLASH_SCALE_W-1:0]))
    else $error("flash scale not updated");
  chk_data_write: assert property (
    s_upd(`IR_FLASH_DATA) |=> fwr_q ##1 ($past(ce) -> !fwr_q))
    else $error("flash data write strobe wrong");
  chk_tdo_enable: assert property (
    (ce && tck_fall && st_q == jtag_decode_pkg::tap_shift_dr) |=> oe_q)
    else $error("output not enabled while shifting");

endmodule : jtag_instruction_decode

// ### jtag_instruction_decode_tb.sv
`timescale 1ns/1ns
`include "jtag_decode_defs.svh"

module jtag_instruction_decode_tb;
  // ========================================================
  // settings and signals
  localparam int           BSR_N = `BSR_LEN_SMALL;          // small package chain
  localparam logic [31:0]  ID_V  = 32'hA5C3_0011;           // arbitrary value
  localparam logic [127:0] PAT   = {4{32'hC3A5_0F96}};      // pin picture
  localparam logic [BSR_N-1:0] NPAT = ~PAT[BSR_N-1:0];      // inverted picture, chain wide
  logic                        mclk        = 1'b0;          // system clock
  logic                        rst_n       = 1'b0;          // reset, active low
  logic                        ce          = 1'b1;          // running, dropped for one frame
  logic                        tck, tms, tdi, tdo, tdo_oe;  // test pins
  logic [BSR_N-1:0]            bsr_capture = PAT[BSR_N-1:0];
  logic [BSR_N-1:0]            bsr_update;
  logic                        bsr_drive;
  logic [`IR_W-1:0]            instr;
  logic [`FLASH_DATA_W-1:0]    flash_rdata = 8'h5A;         // flash read value
  logic [`FLASH_CTRL_W-1:0]    flash_ctrl_reg;
  logic [`FLASH_DATA_W-1:0]    flash_data_reg;
  logic                        flash_data_wr;
  logic [`FLASH_ADDR_W-1:0]    flash_addr_reg;
  logic [`FLASH_SCALE_W-1:0]   flash_timing_scale_reg;
  logic [127:0]                dout;                        // scanned out bits
  logic [15:0]                 got;                         // flash reg view
  int                          bad_count   = 0;
  int                          cmp_count   = 0;
  int                          wr_count    = 0;             // write pulses seen
  int                          oe_count    = 0;             // cycles with output enabled
  int                          cyc         = 0;             // timeout counter
  // flash register table: code, length, written, captured
  logic [15:0] f_code [4] = '{`IR_FLASH_CTRL, `IR_FLASH_DATA, `IR_FLASH_ADDR, `IR_FLASH_SCALE};
  int          f_len  [4] = '{8, 8, 16, 8};
  logic [15:0] f_val  [4] = '{16'h0096, 16'h00C3, 16'hBEEF, 16'h003C};
  logic [15:0] f_cap  [4] = '{16'h0000, 16'h005A, 16'h0000, 16'h0000};
  logic [15:0] b_code [2] = '{`IR_BYPASS, 16'h1234};        // bypass and unknown

  // ========================================================
  // clock, instances, monitors
  always #50 mclk = ~mclk;

  jtag_instruction_decode #(.BSR_LEN(BSR_N), .IDCODE(ID_V)) uut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .bsr_capture(bsr_capture), .bsr_update(bsr_update),
    .bsr_drive(bsr_drive), .instr(instr), .flash_rdata(flash_rdata),
    .flash_ctrl_reg(flash_ctrl_reg), .flash_data_reg(flash_data_reg),
    .flash_data_wr(flash_data_wr), .flash_addr_reg(flash_addr_reg),
    .flash_timing_scale_reg(flash_timing_scale_reg));

  jtag_tester tester (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // count write strobes and cut a hang short
  always @(posedge mclk) begin
    if (flash_data_wr === 1'b1)
      wr_count++;
    if (tdo_oe === 1'b1)
      oe_count++;
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ========================================================
  // compare and verdict
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // ========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    check(instr, `IR_RESET);
    check(bsr_drive, 1'b1);
    check({flash_ctrl_reg, flash_data_reg, flash_addr_reg, flash_timing_scale_reg}, 0);
    check(tdo_oe, 1'b0);
    tester.tap_reset();
    // identification: instruction capture then the id chain
    tester.scan(1'b1, 16, `IR_IDCODE, dout);
    check(dout[15:0], `IR_CAPTURE);
    check(oe_count, 16 * 8);
    check(instr, `IR_IDCODE);
    tester.scan(1'b0, 32, 128'h0, dout);
    check(dout[31:0], ID_V);
    // bypass delays by one bit with a zero in front
    foreach (b_code[i]) begin
      tester.scan(1'b1, 16, b_code[i], dout);
      tester.scan(1'b0, 8, 128'hB6, dout);
      check(dout[7:0], 8'h6C);
    end
    // flash registers: each code, its length and its output
    foreach (f_code[i]) begin
      tester.scan(1'b1, 16, f_code[i], dout);
      check(instr, f_code[i]);
      tester.scan(1'b0, f_len[i], f_val[i], dout);
      check(dout[15:0], f_cap[i]);
      case (i)
        0: got = {8'h00, flash_ctrl_reg};
        1: got = {8'h00, flash_data_reg};
        2: got = flash_addr_reg;
        default: got = {8'h00, flash_timing_scale_reg};
      endcase
      check(got, f_val[i]);
    end
    check(wr_count, 1);
    // address register keeps and returns its contents
    tester.scan(1'b1, 16, `IR_FLASH_ADDR, dout);
    tester.scan(1'b0, 16, 128'h0123, dout);
    check(dout[15:0], 16'hBEEF);
    check(flash_addr_reg, 16'h0123);
    // clock enable low: a whole frame goes unseen
    ce <= 1'b0;
    tester.scan(1'b1, 16, `IR_BYPASS, dout);
    ce <= 1'b1;
    check(instr, `IR_FLASH_ADDR);
    // external test: capture out, update latch written
    tester.scan(1'b1, 16, `IR_EXTEST, dout);
    check(bsr_drive, 1'b1);
    tester.scan(1'b0, BSR_N, ~PAT, dout);
    check(dout[BSR_N-1:0], PAT[BSR_N-1:0]);
    check(bsr_update, NPAT);
    // sample: new pin picture captured, latch untouched
    bsr_capture <= NPAT;
    tester.scan(1'b1, 16, `IR_SAMPLE, dout);
    check(bsr_drive, 1'b0);
    tester.scan(1'b0, BSR_N, PAT, dout);
    check(dout[BSR_N-1:0], NPAT);
    check(bsr_update, NPAT);
    // test-logic reset by mode pin restores external test
    tester.tap_reset();
    check(instr, `IR_RESET);
    check(bsr_drive, 1'b1);
    tally_and_finish();
  end
endmodule : jtag_instruction_decode_tb

// ### jtag_tester.sv
`timescale 1ns/1ns

// ==========================================================
// external test controller: drives clock, mode and data in,
// samples data out; test clock stands low between frames
module jtag_tester (
  input  wire logic mclk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  // idle pin levels at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // ========================================================
  // one test clock period of 8 mclk: fall, new mode/data,
  // rise, then data out sampled late in the high phase
  task automatic step(input logic tms_v, input logic tdi_v, output logic tdo_s);
    tck <= 1'b0;
    repeat (2) @(posedge mclk);
    tms <= tms_v;
    tdi <= tdi_v;
    repeat (2) @(posedge mclk);
    tck <= 1'b1;
    repeat (4) @(posedge mclk);
    tdo_s = tdo;
  endtask : step

  // park the clock low for a while after a frame
  task automatic pause();
    tck <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask : pause

  // five mode-high clocks reach test-logic reset, then idle
  task automatic tap_reset();
    logic s;
    for (int i = 0; i < 5; i++)
      step(1'b1, ~tdi, s);
    step(1'b0, ~tdi, s);
    pause();
  endtask : tap_reset

  // ========================================================
  // full scan from idle back to idle, least significant first;
  // outside shifting the data line toggles so no stale level
  task automatic scan(input logic is_ir, input int len, input logic [127:0] din,
                      output logic [127:0] dout);
    logic s;
    dout = '0;
    step(1'b1, ~tdi, s);
    if (is_ir)
      step(1'b1, ~tdi, s);
    step(1'b0, ~tdi, s);
    step(1'b0, ~tdi, s);
    for (int i = 0; i < len; i++) begin
      step(i == len - 1, din[i], s);
      dout[i] = s;
    end
    step(1'b1, ~tdi, s);
    step(1'b0, ~tdi, s);
    pause();
  endtask : scan
endmodule : jtag_tester

// ### pin_sync.sv
`timescale 1ns/1ns
`include "jtag_decode_defs.svh"

// three-stage pin synchroniser; a level is accepted once the
// second and third stages agree
module pin_sync #(
  parameter int W = 3
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level
);

  // ========================================================
  // per-bit chain
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      logic [`SYNC_STAGES-1:0] st_q;  // stage flops
      logic [`SYNC_STAGES-1:0] st_d;  // next stage values
      logic                    lv_q;  // accepted level
      logic                    lv_d;  // next accepted level

      // shift chain, accept when stages two and three agree
      always_comb begin
        st_d = {st_q[`SYNC_STAGES-2:0], pin[gi]};
        lv_d = (st_q[1] == st_q[2]) ? st_q[2] : lv_q;
      end

      // register stages
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          st_q <= '0;
          lv_q <= 1'b0;
        end else if (ce) begin
          st_q <= st_d;
          lv_q <= lv_d;
        end
      end

      assign level[gi] = lv_q;
    end
  endgenerate

endmodule : pin_sync
